// File: lid_decoder.sv
// Instruction decoder and control state for the grayscale display controller
//
// Notes on behaviour
// - Hw init: duty 1/128, no N-line inversion, reverse/all-on/symbol/display off.
// - Hw init clears power enables and step-up, bias 1/12, scan bits, oscillator, sleep.
// - Any init: page, column zero, modify-read off, start line zero, ratio 0, contrast 32.
// - Any init: byte count and gray mode flags clear, palettes 0000/0000/1111/1111, 4FRC 9PWM.
// - Software init leaves display, power, bias, scan, duty, row, inversion, oscillator alone.
// - During init only status read is accepted; host waits for init bit low.
// - Select and direction choose data read, data write, status read or command.
// - Data read returns current byte, column plus one; first read after address is dummy.
// - Serial port carries no RAM read path.
// - Data write stores byte, column plus one, wrapping to zero after the last.
// - Busy bit high during init only, same as init bit; commands rejected meanwhile.
// - Status byte: busy bit 7, display on bit 6, init bit 5, low bits 00010.
// - Symbol row command stores enable; setting it forces page 16.
// - Separate commands load page, column upper three bits and column lower four bits.
// - One command enters modify-read, another leaves it.
// - Two-byte commands load seven-bit start line and first row.
// - Two-byte commands load duty, N-line inversion and six-bit contrast.
// - One-byte command cancels N-line inversion.
// - One-byte commands store display on, reverse and all-on from bit 0.
// - One-byte commands load power enables, step-up, resistor ratio and bias.
// - One-byte commands set scan bits, oscillator, sleep, software init, no-op.
// - Byte-count command: two bytes, select/direction ignored, second is count.
// - Gray method command picks 3 or 4 frame FRAME_RATE_CTRL and 9/9/12/15 PWM.
// - Per gray level, two commands load two 4-bit pulse widths each.
// - Modify-read: reads hold column, writes advance; leaving restores entry column.
// - Duty codes 16 to 128 accepted, others ignored.
`timescale 1ns/1ps

module lid_decoder (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // Pins from host
    input  wire logic                 hw_init_n,
    input  wire logic                 serial_mode,
    // Host access
    input  wire logic                 acc_valid,
    output logic                      acc_ready,
    input  wire logic                 cmd_data_sel,
    input  wire logic                 acc_read,
    input  wire logic [7:0]           acc_wdata,
    output logic                      rd_valid,
    output logic [7:0]                rd_data,
    // Display RAM port
    output logic                      ram_valid,
    input  wire logic                 ram_ready,
    output lid_pkg::lid_ram_type      ram_req,
    input  wire logic [7:0]           ram_rdata,
    // Status and settings
    output logic                      busy,
    output logic                      init_in_progress,
    output lid_pkg::lid_cfg_type      cfg
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0]             hw_sync;
        logic [2:0]             init_cnt;
        logic                   init_act;
        logic                   hw_init;
        lid_pkg::lid_arg_type   arg;
        logic [2:0]             pal_sel;
        logic [4:0]             page;
        logic [6:0]             column;
        logic                   modify_read;
        logic [6:0]             mr_column;
        logic [7:0]             read_latch;
        logic                   rd_valid;
        logic [7:0]             rd_data;
        logic [1:0]             buf_cnt;
        lid_pkg::lid_ram_type   buf0;
        lid_pkg::lid_ram_type   buf1;
        lid_pkg::lid_cfg_type   cfg;
    } lid_state_type;

    lid_state_type s_r;
    lid_state_type s_nxt;

    function automatic logic hit(input logic [7:0] b, input logic [7:0] op,
                                 input logic [7:0] mask);
        hit = (b & mask) == op;
    endfunction

    function automatic logic [6:0] col_inc(input logic [6:0] c);
        col_inc = (c == lid_pkg::COL_LAST) ? 7'h00 : c + 7'h01;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Data reads wait for an empty buffer so they never overtake a pending write
    logic take;
    logic is_cmd;
    logic rd_stall;
    logic [7:0] b;

    assign b         = acc_wdata;
    assign rd_stall  = cmd_data_sel && acc_read && s_r.buf_cnt != 2'd0;
    assign acc_ready = clk_en && s_r.buf_cnt != 2'd2 && !rd_stall;
    assign take      = acc_valid && acc_ready;
    assign is_cmd    = (!cmd_data_sel && !acc_read) || s_r.arg == lid_pkg::ST_COUNT;

    always_comb begin
        s_nxt = s_r;
        s_nxt.hw_sync  = {s_r.hw_sync[0], hw_init_n};
        s_nxt.rd_valid = 1'b0;
        // Buffer drain
        if (ram_valid && ram_ready) begin
            s_nxt.buf0    = s_r.buf1;
            s_nxt.buf_cnt = s_r.buf_cnt - 2'd1;
        end
        if (s_r.init_act) begin
            s_nxt.init_cnt = s_r.init_cnt - 3'd1;
            if (s_r.init_cnt == 3'd0) begin
                s_nxt.init_act = 1'b0;
                s_nxt.hw_init  = 1'b0;
            end
        end
        if (take && acc_read && !cmd_data_sel && !is_cmd) begin
            s_nxt.rd_valid = 1'b1;
            s_nxt.rd_data  = {busy, s_r.cfg.display_on, init_in_progress,
                              lid_pkg::STATUS_LOW};
        end else if (take && busy && s_r.arg != lid_pkg::ST_COUNT) begin
            // Rejected during init, status read only
        end else if (take && cmd_data_sel && acc_read && !is_cmd && !serial_mode) begin
            // Data read returns latched byte, latch refills
            s_nxt.rd_valid   = 1'b1;
            s_nxt.rd_data    = s_r.read_latch;
            s_nxt.read_latch = ram_rdata;
            if (!s_r.modify_read) begin
                s_nxt.column = col_inc(s_r.column);
            end
        end else if (take && cmd_data_sel && !acc_read && !is_cmd) begin
            // Data write queued in the buffer
            if (s_nxt.buf_cnt == 2'd0) begin
                s_nxt.buf0 = '{1'b1, s_r.page, s_r.column, b};
            end else begin
                s_nxt.buf1 = '{1'b1, s_r.page, s_r.column, b};
            end
            s_nxt.buf_cnt = s_nxt.buf_cnt + 2'd1;
            s_nxt.column  = col_inc(s_r.column);
        end else if (take && is_cmd) begin
            s_nxt.arg = lid_pkg::ST_IDLE;
            case (s_r.arg)
                lid_pkg::ST_START:     s_nxt.cfg.start_line_bits = b[6:0];
                lid_pkg::ST_FIRST_ROW: s_nxt.cfg.first_common_bits = b[6:0];
                lid_pkg::ST_DUTY: begin
                    if (b >= lid_pkg::DUTY_MIN && b <= lid_pkg::DUTY_MAX) begin
                        s_nxt.cfg.partial_duty = b;
                    end
                end
                lid_pkg::ST_NLINE:     s_nxt.cfg.inversion_line_count = b[4:0];
                lid_pkg::ST_CONTRAST:  s_nxt.cfg.contrast_bits = b[5:0];
                lid_pkg::ST_COUNT:     s_nxt.cfg.spi_byte_count = b;
                lid_pkg::ST_PALETTE: begin
                    s_nxt.cfg.gray_mode[s_r.pal_sel[2:1]] = 1'b1;
                    if (s_r.pal_sel[0]) begin
                        s_nxt.cfg.palette[s_r.pal_sel[2:1]][15:8] = b;
                    end else begin
                        s_nxt.cfg.palette[s_r.pal_sel[2:1]][7:0] = b;
                    end
                end
                default: begin
                    // unmatched codes fall through
                    if (b == lid_pkg::OP_MR_SET) begin
                        s_nxt.modify_read = 1'b1;
                        s_nxt.mr_column   = s_r.column;
                    end else if (b == lid_pkg::OP_MR_CLR) begin
                        s_nxt.modify_read = 1'b0;
                        if (s_r.modify_read) begin
                            s_nxt.column = s_r.mr_column;
                        end
                    end else if (b == lid_pkg::OP_NLINE_OFF) begin
                        s_nxt.cfg.inversion_line_count = 5'h00;
                    end else if (b == lid_pkg::OP_OSC_ON) begin
                        s_nxt.cfg.osc_on = 1'b1;
                    end else if (b == lid_pkg::OP_SLEEP_OFF) begin
                        s_nxt.cfg.sleep = 1'b0;
                    end else if (b == lid_pkg::OP_SW_INIT) begin
                        s_nxt.init_act = 1'b1;
                        s_nxt.init_cnt = 3'(lid_pkg::INIT_CYCLES);
                    end else if (b == lid_pkg::OP_NOP) begin
                        s_nxt.arg = lid_pkg::ST_IDLE;
                    end else if (b == lid_pkg::OP_BYTE_COUNT) begin
                        s_nxt.arg = lid_pkg::ST_COUNT;
                    end else if (b == lid_pkg::OP_CONTRAST) begin
                        s_nxt.arg = lid_pkg::ST_CONTRAST;
                    end else if (hit(b, lid_pkg::OP_TEST, 8'hf0)) begin
                        s_nxt.arg = lid_pkg::ST_IDLE;
                    end else if (hit(b, lid_pkg::OP_SYMBOL, 8'hfe)) begin
                        s_nxt.cfg.symbol_row = b[0];
                        if (b[0]) begin
                            s_nxt.page = {1'b1, lid_pkg::SYMBOL_PAGE};
                        end
                    end else if (hit(b, lid_pkg::OP_DISP_ON, 8'hfe)) begin
                        s_nxt.cfg.display_on = b[0];
                    end else if (hit(b, lid_pkg::OP_REVERSE, 8'hfe)) begin
                        s_nxt.cfg.invert_gray = b[0];
                    end else if (hit(b, lid_pkg::OP_ALL_ON, 8'hfe)) begin
                        s_nxt.cfg.force_all_on = b[0];
                    end else if (hit(b, lid_pkg::OP_COL_SCAN, 8'hfe)) begin
                        s_nxt.cfg.col_scan_reverse = b[0];
                    end else if (hit(b, lid_pkg::OP_SLEEP, 8'hfe)) begin
                        s_nxt.cfg.sleep = b[0];
                    end else if (hit(b, lid_pkg::OP_PAGE, 8'hf0)) begin
                        s_nxt.page = {1'b0, b[3:0]};
                    end else if (hit(b, lid_pkg::OP_COL_HI, 8'hf8)) begin
                        s_nxt.column[6:4] = b[2:0];
                    end else if (hit(b, lid_pkg::OP_COL_LO, 8'hf0)) begin
                        s_nxt.column[3:0] = b[3:0];
                    end else if (hit(b, lid_pkg::OP_ROW_SCAN, 8'hf0)) begin
                        s_nxt.cfg.row_scan_reverse = b[3];
                    end else if (hit(b, lid_pkg::OP_START, 8'hfc)) begin
                        s_nxt.arg = lid_pkg::ST_START;
                    end else if (hit(b, lid_pkg::OP_FIRST_ROW, 8'hfc)) begin
                        s_nxt.arg = lid_pkg::ST_FIRST_ROW;
                    end else if (hit(b, lid_pkg::OP_DUTY, 8'hfc)) begin
                        s_nxt.arg = lid_pkg::ST_DUTY;
                    end else if (hit(b, lid_pkg::OP_NLINE, 8'hfc)) begin
                        s_nxt.arg = lid_pkg::ST_NLINE;
                    end else if (hit(b, lid_pkg::OP_POWER, 8'hf8)) begin
                        s_nxt.cfg.booster_enable   = b[2];
                        s_nxt.cfg.regulator_enable = b[1];
                        s_nxt.cfg.follower_enable  = b[0];
                    end else if (hit(b, lid_pkg::OP_BOOST, 8'hfc)) begin
                        s_nxt.cfg.boost_step_select = b[1:0];
                    end else if (hit(b, lid_pkg::OP_RESISTOR, 8'hf8)) begin
                        s_nxt.cfg.resistor_ratio = b[2:0];
                    end else if (hit(b, lid_pkg::OP_BIAS, 8'hf8)) begin
                        s_nxt.cfg.bias_code = b[2:0];
                    end else if (hit(b, lid_pkg::OP_GRAY_METH, 8'hf8)) begin
                        s_nxt.cfg.frame_rate_ctrl = b[2];
                        s_nxt.cfg.pwm_steps       = b[1:0];
                    end else if (hit(b, lid_pkg::OP_PALETTE, 8'hf8)) begin
                        s_nxt.arg     = lid_pkg::ST_PALETTE;
                        s_nxt.pal_sel = b[2:0];
                    end
                end
            endcase
        end
        // Hardware init, applied on every cycle that the synchronised level is low
        if (!s_r.hw_sync[1]) begin
            s_nxt.hw_init  = 1'b1;
            s_nxt.init_act = 1'b1;
            s_nxt.init_cnt = 3'(lid_pkg::INIT_CYCLES);
            s_nxt.cfg.display_on           = 1'b0;
            s_nxt.cfg.invert_gray          = 1'b0;
            s_nxt.cfg.force_all_on         = 1'b0;
            s_nxt.cfg.symbol_row           = 1'b0;
            s_nxt.cfg.partial_duty         = lid_pkg::DUTY_RST;
            s_nxt.cfg.inversion_line_count = 5'h00;
            s_nxt.cfg.first_common_bits    = 7'h00;
            s_nxt.cfg.booster_enable       = 1'b0;
            s_nxt.cfg.regulator_enable     = 1'b0;
            s_nxt.cfg.follower_enable      = 1'b0;
            s_nxt.cfg.boost_step_select    = 2'h0;
            s_nxt.cfg.bias_code            = lid_pkg::BIAS_RST;
            s_nxt.cfg.row_scan_reverse     = 1'b0;
            s_nxt.cfg.col_scan_reverse     = 1'b0;
            s_nxt.cfg.osc_on               = 1'b0;
            s_nxt.cfg.sleep                = 1'b0;
        end
        // Shared init defaults; software init touches only these
        if (!s_r.hw_sync[1] || (s_nxt.init_act && !s_r.init_act)) begin
            s_nxt.arg                  = lid_pkg::ST_IDLE;
            s_nxt.page                 = 5'h00;
            s_nxt.column               = 7'h00;
            s_nxt.modify_read          = 1'b0;
            s_nxt.cfg.start_line_bits  = 7'h00;
            s_nxt.cfg.resistor_ratio   = 3'h0;
            s_nxt.cfg.contrast_bits    = lid_pkg::CONTRAST_RST;
            s_nxt.cfg.spi_byte_count   = 8'h00;
            s_nxt.cfg.gray_mode        = 4'h0;
            s_nxt.cfg.palette[0]       = {4{lid_pkg::PAL_LIGHT_RST}};
            s_nxt.cfg.palette[1]       = {4{lid_pkg::PAL_LIGHT_RST}};
            s_nxt.cfg.palette[2]       = {4{lid_pkg::PAL_DARK_RST}};
            s_nxt.cfg.palette[3]       = {4{lid_pkg::PAL_DARK_RST}};
            s_nxt.cfg.frame_rate_ctrl  = 1'b0;
            s_nxt.cfg.pwm_steps        = 2'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r         <= '0;
            s_r.hw_sync <= 2'b11;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign init_in_progress = s_r.init_act;
    assign busy             = s_r.init_act;
    assign rd_valid         = s_r.rd_valid;
    assign rd_data          = s_r.rd_data;
    assign ram_valid        = s_r.buf_cnt != 2'd0;
    assign ram_req          = ram_valid ? s_r.buf0 : '{1'b0, s_r.page, s_r.column, 8'h00};
    assign cfg              = s_r.cfg;

endmodule

// File: lid_decoder_properties.sv
// Concurrent checks on the decoder's ports
`timescale 1ns/1ps

module lid_decoder_properties (
    // Clock and pins
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire logic                 clk_en,
    input wire logic                 hw_init_n,
    input wire logic                 serial_mode,
    // Host access
    input wire logic                 acc_valid,
    input wire logic                 acc_ready,
    input wire logic                 cmd_data_sel,
    input wire logic                 acc_read,
    input wire logic [7:0]           acc_wdata,
    input wire logic                 rd_valid,
    input wire logic [7:0]           rd_data,
    // RAM side and settings
    input wire logic                 ram_valid,
    input wire logic                 ram_ready,
    input wire lid_pkg::lid_ram_type ram_req,
    input wire logic [7:0]           ram_rdata,
    input wire logic                 busy,
    input wire logic                 init_in_progress,
    input wire lid_pkg::lid_cfg_type cfg
);
    wire tk = acc_valid && acc_ready;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    a_busy_tracks_init: assert property (busy == init_in_progress)
        else $error("busy differs from init flag");
    a_init_sets_defaults: assert property (!hw_init_n [*4] |=>
        cfg.partial_duty == lid_pkg::DUTY_RST && cfg.bias_code == lid_pkg::BIAS_RST
        && cfg.contrast_bits == lid_pkg::CONTRAST_RST && !cfg.display_on)
        else $error("init defaults missing");
    a_init_busy_len: assert property ($rose(hw_init_n) |-> busy [*4] ##[1:6] !busy)
        else $error("init busy length wrong");
    a_busy_refuses_cmd: assert property (busy && tk && !cmd_data_sel && !acc_read
        |=> $stable(cfg.display_on)) else $error("command taken while busy");
    a_status_byte_bits: assert property (tk && !cmd_data_sel && acc_read |=> rd_valid
        && rd_data[4:0] == lid_pkg::STATUS_LOW && rd_data[7] == $past(busy)
        && rd_data[6] == $past(cfg.display_on)) else $error("status byte wrong");
    a_serial_no_read: assert property (tk && serial_mode && cmd_data_sel && acc_read
        |=> !rd_valid) else $error("serial data read answered");
    a_write_to_ram: assert property (tk && cmd_data_sel && !acc_read && !busy && !ram_valid
        |=> ram_valid && ram_req.write && ram_req.data == $past(acc_wdata))
        else $error("data write not queued");
    a_ram_req_held: assert property (ram_valid && !ram_ready |=> ram_valid && $stable(ram_req))
        else $error("stalled RAM request changed");
    a_read_waits_drain: assert property (acc_valid && cmd_data_sel && acc_read && ram_valid
        && !serial_mode |-> !acc_ready) else $error("read passed pending write");
    c_data_write: cover property (tk && cmd_data_sel && !acc_read);
    c_ram_stall: cover property (ram_valid && !ram_ready);
    c_busy_status: cover property (tk && !cmd_data_sel && acc_read && busy);
endmodule

bind lid_decoder lid_decoder_properties u_lid_decoder_properties (.clock(clock), .rst_n(rst_n),
    .clk_en(clk_en), .hw_init_n(hw_init_n), .serial_mode(serial_mode), .acc_valid(acc_valid),
    .acc_ready(acc_ready), .cmd_data_sel(cmd_data_sel), .acc_read(acc_read),
    .acc_wdata(acc_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .ram_valid(ram_valid),
    .ram_ready(ram_ready), .ram_req(ram_req), .ram_rdata(ram_rdata), .busy(busy),
    .init_in_progress(init_in_progress), .cfg(cfg));

// File: lid_decoder_test.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps

module lid_decoder_test;
    logic clock = 0, rst_n = 0, hw_init_n = 0, serial_mode = 0, acc_valid = 0;
    logic cmd_data_sel = 0, acc_read = 0, stall = 0, acc_ready, rd_valid, ram_valid, ram_ready;
    logic busy, init_in_progress;
    logic [7:0] acc_wdata = 8'h00, rd_data, ram_rdata;
    lid_pkg::lid_ram_type ram_req;
    lid_pkg::lid_cfg_type cfg;
    int errors = 0, comparisons = 0, cycles = 0;

    always #2.5 clock = ~clock;
    lid_decoder u_lid_decoder (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
        .hw_init_n(hw_init_n), .serial_mode(serial_mode), .acc_valid(acc_valid),
        .acc_ready(acc_ready), .cmd_data_sel(cmd_data_sel), .acc_read(acc_read),
        .acc_wdata(acc_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .ram_valid(ram_valid),
        .ram_ready(ram_ready), .ram_req(ram_req), .ram_rdata(ram_rdata), .busy(busy),
        .init_in_progress(init_in_progress), .cfg(cfg));
    lid_ram_model u_lid_ram_model (.clock(clock), .stall(stall), .ram_valid(ram_valid),
        .ram_ready(ram_ready), .ram_req(ram_req), .ram_rdata(ram_rdata));
    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    // Holds the request until taken, then one idle edge
    task acc(input logic s, input logic r, input logic [7:0] d);
        acc_valid <= 1'b1; cmd_data_sel <= s; acc_read <= r; acc_wdata <= d;
        do @(posedge clock); while (acc_ready !== 1'b1);
        acc_valid <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input logic s, input logic [7:0] exp);
        acc(s, 1'b1, 8'h00);
        chk("rd_valid", 16'h1, {15'h0, rd_valid});
        chk("rd_data", {8'h00, exp}, {8'h00, rd_data});
    endtask
    task cmds(input logic [7:0] b []);
        foreach (b[i]) acc(1'b0, 1'b0, b[i]);
    endtask
    task wait_idle;
        repeat (40) if (busy !== 1'b0 || ram_valid !== 1'b0) @(posedge clock);
        chk("busy", 16'h0, {15'h0, busy});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_init;
        repeat (8) @(posedge clock);
        rd(1'b0, 8'ha2);
        acc(1'b0, 1'b0, 8'haf);
        hw_init_n <= 1'b1;
        wait_idle;
        chk("display_on", 16'h0, {15'h0, cfg.display_on});
        chk("duty", 16'h80, {8'h00, cfg.partial_duty});
        chk("bias", 16'h7, {13'h0, cfg.bias_code});
        chk("contrast", 16'h20, {10'h0, cfg.contrast_bits});
        chk("black", 16'hffff, cfg.palette[3]);
        rd(1'b0, 8'h02);
    endtask
    task t_cmds;
        cmds('{8'haf, 8'h81, 8'h3f, 8'h48, 8'h10, 8'h48, 8'h81, 8'h4c, 8'h1f});
        chk("inversion", 16'h1f, {11'h0, cfg.inversion_line_count});
        cmds('{8'he4, 8'h2f, 8'h53, 8'h97, 8'h88, 8'h5a, 8'he8});
        acc(1'b1, 1'b1, 8'h07);
        chk("display_on", 16'h1, {15'h0, cfg.display_on});
        chk("contrast", 16'h3f, {10'h0, cfg.contrast_bits});
        chk("duty", 16'h10, {8'h00, cfg.partial_duty});
        chk("inversion", 16'h0, {11'h0, cfg.inversion_line_count});
        chk("power", 16'h7, {13'h0, cfg.booster_enable, cfg.regulator_enable,
            cfg.follower_enable});
        chk("bias", 16'h3, {13'h0, cfg.bias_code});
        chk("gray", 16'h7, {13'h0, cfg.frame_rate_ctrl, cfg.pwm_steps});
        chk("white", 16'h005a, cfg.palette[0]);
        chk("count", 16'h07, {8'h00, cfg.spi_byte_count});
        rd(1'b0, 8'h42);
    endtask
    task t_data;
        stall <= 1'b1;
        cmds('{8'hb3, 8'h17, 8'h0f});
        acc(1'b1, 1'b0, 8'ha5);
        acc(1'b1, 1'b0, 8'h5c);
        chk("ram_valid", 16'h1, {15'h0, ram_valid});
        stall <= 1'b0;
        wait_idle;
        chk("ram_last", 16'ha5, {8'h00, u_lid_ram_model.mem[{5'h03, 7'h7f}]});
        chk("ram_wrap", 16'h5c, {8'h00, u_lid_ram_model.mem[{5'h03, 7'h00}]});
        cmds('{8'h17, 8'h0f});
        acc(1'b1, 1'b1, 8'h00);
        rd(1'b1, 8'ha5);
        rd(1'b1, 8'h5c);
        acc(1'b0, 1'b0, 8'he0);
        acc(1'b1, 1'b1, 8'h00);
        acc(1'b1, 1'b0, 8'h33);
        wait_idle;
        acc(1'b0, 1'b0, 8'hee);
        acc(1'b1, 1'b1, 8'h00);
        rd(1'b1, 8'h33);
    endtask
    task t_serial_sw;
        serial_mode <= 1'b1;
        acc(1'b1, 1'b1, 8'h00);
        chk("rd_valid", 16'h0, {15'h0, rd_valid});
        serial_mode <= 1'b0;
        acc(1'b0, 1'b0, 8'he2);
        acc(1'b0, 1'b0, 8'hae);
        wait_idle;
        chk("contrast", 16'h20, {10'h0, cfg.contrast_bits});
        chk("white", 16'h0000, cfg.palette[0]);
        chk("display_on", 16'h1, {15'h0, cfg.display_on});
        chk("duty", 16'h10, {8'h00, cfg.partial_duty});
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Hang guard, well above the roughly hundred cycles needed
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            stop_test;
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_init;
        t_cmds;
        t_data;
        t_serial_sw;
        stop_test;
    end
endmodule

// File: lid_pkg.sv
// Package with constants and types for the display instruction decoder
package lid_pkg;

    // Command opcodes (full byte)
    localparam logic [7:0] OP_MR_SET     = 8'he0;
    localparam logic [7:0] OP_MR_CLR     = 8'hee;
    localparam logic [7:0] OP_NLINE_OFF  = 8'he4;
    localparam logic [7:0] OP_OSC_ON     = 8'hab;
    localparam logic [7:0] OP_SLEEP_OFF  = 8'he1;
    localparam logic [7:0] OP_SW_INIT    = 8'he2;
    localparam logic [7:0] OP_NOP        = 8'he3;
    localparam logic [7:0] OP_BYTE_COUNT = 8'he8;
    localparam logic [7:0] OP_CONTRAST   = 8'h81;
    // Command prefixes, compared under mask
    localparam logic [7:0] OP_SYMBOL     = 8'ha2;
    localparam logic [7:0] OP_DISP_ON    = 8'hae;
    localparam logic [7:0] OP_REVERSE    = 8'ha6;
    localparam logic [7:0] OP_ALL_ON     = 8'ha4;
    localparam logic [7:0] OP_COL_SCAN   = 8'ha0;
    localparam logic [7:0] OP_SLEEP      = 8'ha8;
    localparam logic [7:0] OP_PAGE       = 8'hb0;
    localparam logic [7:0] OP_COL_HI     = 8'h10;
    localparam logic [7:0] OP_COL_LO     = 8'h00;
    localparam logic [7:0] OP_ROW_SCAN   = 8'hc0;
    localparam logic [7:0] OP_START      = 8'h40;
    localparam logic [7:0] OP_FIRST_ROW  = 8'h44;
    localparam logic [7:0] OP_DUTY       = 8'h48;
    localparam logic [7:0] OP_NLINE      = 8'h4c;
    localparam logic [7:0] OP_POWER      = 8'h28;
    localparam logic [7:0] OP_BOOST      = 8'h64;
    localparam logic [7:0] OP_RESISTOR   = 8'h20;
    localparam logic [7:0] OP_BIAS       = 8'h50;
    localparam logic [7:0] OP_GRAY_METH  = 8'h90;
    localparam logic [7:0] OP_PALETTE    = 8'h88;
    localparam logic [7:0] OP_TEST       = 8'hf0;

    // Reset values and limits
    localparam logic [7:0] DUTY_RST      = 8'h80;
    localparam logic [7:0] DUTY_MIN      = 8'h10;
    localparam logic [7:0] DUTY_MAX      = 8'h80;
    localparam logic [2:0] BIAS_RST      = 3'h7;
    localparam logic [5:0] CONTRAST_RST  = 6'h20;
    localparam logic [3:0] PAL_LIGHT_RST = 4'h0;
    localparam logic [3:0] PAL_DARK_RST  = 4'hf;
    localparam logic [3:0] SYMBOL_PAGE   = 4'h0;
    localparam logic [4:0] STATUS_LOW    = 5'h02;
    localparam logic [6:0] COL_LAST      = 7'h7f;
    localparam int         INIT_CYCLES   = 4;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_START     = 3'b001,
        ST_FIRST_ROW = 3'b010,
        ST_DUTY      = 3'b011,
        ST_NLINE     = 3'b100,
        ST_CONTRAST  = 3'b101,
        ST_COUNT     = 3'b110,
        ST_PALETTE   = 3'b111
    } lid_arg_type;

    // Settings handed to display and power circuits
    typedef struct packed {
        logic       display_on;
        logic       invert_gray;
        logic       force_all_on;
        logic       symbol_row;
        logic [7:0] partial_duty;
        logic [4:0] inversion_line_count;
        logic [6:0] start_line_bits;
        logic [6:0] first_common_bits;
        logic       booster_enable;
        logic       regulator_enable;
        logic       follower_enable;
        logic [1:0] boost_step_select;
        logic [2:0] resistor_ratio;
        logic [2:0] bias_code;
        logic [5:0] contrast_bits;
        logic       row_scan_reverse;
        logic       col_scan_reverse;
        logic       osc_on;
        logic       sleep;
        logic [7:0] spi_byte_count;
        logic       frame_rate_ctrl;
        logic [1:0] pwm_steps;
        logic [3:0] gray_mode;
        logic [3:0][15:0] palette;
    } lid_cfg_type;

    // RAM access request
    typedef struct packed {
        logic       write;
        logic [4:0] page;
        logic [6:0] column;
        logic [7:0] data;
    } lid_ram_type;

endpackage

// File: lid_ram_model.sv
// Display RAM model behind the decoder's write buffer
`timescale 1ns/1ps

module lid_ram_model (
    input wire logic                 clock,
    input wire logic                 stall,
    input wire logic                 ram_valid,
    output logic                     ram_ready,
    input wire lid_pkg::lid_ram_type ram_req,
    output logic [7:0]               ram_rdata
);
    logic [7:0] mem [4096];
    // Slow answers on request, so the buffer must hold its words
    assign ram_ready = !stall;
    assign ram_rdata = mem[{ram_req.page, ram_req.column}];
    initial foreach (mem[i]) mem[i] = 8'h00;
    always @(posedge clock) begin
        if (ram_valid && ram_ready && ram_req.write)
            mem[{ram_req.page, ram_req.column}] <= ram_req.data;
    end
endmodule
